/* include/dstp_pkg.sv */
// package: constants and state codes for the debug serial trace port
package dstp_pkg;
    // debug serial interface states (sixteen-state test-access style machine)
    typedef enum logic [3:0] {
        DSTP_RESET    = 4'h0,
        DSTP_IDLE     = 4'h1,
        DSTP_SEL_DR   = 4'h2,
        DSTP_CAP_DR   = 4'h3,
        DSTP_SHIFT_DR = 4'h4,
        DSTP_EXIT1_DR = 4'h5,
        DSTP_PAUSE_DR = 4'h6,
        DSTP_EXIT2_DR = 4'h7,
        DSTP_UPD_DR   = 4'h8,
        DSTP_SEL_IR   = 4'h9,
        DSTP_CAP_IR   = 4'hA,
        DSTP_SHIFT_IR = 4'hB,
        DSTP_EXIT1_IR = 4'hC,
        DSTP_PAUSE_IR = 4'hD,
        DSTP_EXIT2_IR = 4'hE,
        DSTP_UPD_IR   = 4'hF
    } dstp_state_t;

    localparam int          DSTP_DR_WIDTH   = 32;
    localparam int          DSTP_IR_WIDTH   = 4;
    localparam int          DSTP_NIBBLE_W   = 4;
    localparam int          DSTP_TRACE_W    = 32;
    localparam logic [31:0] DSTP_DR_RESET   = 32'h0000_0000;
    localparam logic [3:0]  DSTP_IR_RESET   = 4'h0;
    localparam logic [3:0]  DSTP_IR_CAPTURE = 4'h1;
    localparam logic [2:0]  DSTP_NIB_LAST   = 3'h7;
endpackage

/* logic/dstp_sync.sv */
// two-flop synchroniser for pins arriving from outside the core clock domain
`timescale 1ns/1ps
module dstp_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic             clk_en_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    // widths the reset constant cannot cover are refused at elaboration
    if (WIDTH < 1 || WIDTH > 32) begin : g_width_bad
        $error("dstp_sync: WIDTH out of range");
    end

    // first stage feeds only the second stage
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_reg <= RESET_VAL[WIDTH-1:0];
            sync_o   <= RESET_VAL[WIDTH-1:0];
        end else if (clk_en_i) begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

/* logic/dstp_top.sv */
// debug serial port with nibble-wide packet trace output
`timescale 1ns/1ps
module dstp_top
    import dstp_pkg::*;
#(
    parameter int DR_WIDTH = DSTP_DR_WIDTH,
    parameter int IR_WIDTH = DSTP_IR_WIDTH
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    clk_en_i,
    input  wire logic                    dbg_serial_clk_i,
    input  wire logic                    dbg_mode_select_i,
    input  wire logic                    dbg_serial_in_i,
    input  wire logic                    dbg_reset_n_i,
    output logic                         dbg_serial_out_o,
    output logic                         dbg_serial_out_oe_o,
    input  wire logic [DR_WIDTH-1:0]     dr_capture_i,
    output logic      [DR_WIDTH-1:0]     dr_update_o,
    output logic                         dr_update_stb_o,
    output logic      [IR_WIDTH-1:0]     instr_o,
    output logic                         unit_enabled_o,
    input  wire logic                    trace_valid_i,
    input  wire logic [DSTP_TRACE_W-1:0] trace_word_i,
    output logic                         trace_ready_o,
    output logic                         bus_clock_out_o,
    output logic      [DSTP_NIBBLE_W-1:0] trace_out_nibble_o,
    output logic                         trace_active_o
);
    // widths the shift and update logic cannot serve are refused at elaboration
    if (DR_WIDTH < 2 || DR_WIDTH > 32 || IR_WIDTH < 2 || IR_WIDTH > 8) begin : g_width_bad
        $error("dstp_top: register width out of range");
    end

    // pins from the probe are asynchronous; reset_n idles low so its synchroniser resets low
    logic [3:0] pins_sync;
    dstp_sync #(
        .WIDTH     (4),
        .RESET_VAL (32'h0000_0007)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .async_i    ({dbg_reset_n_i, dbg_serial_clk_i, dbg_mode_select_i, dbg_serial_in_i}),
        .sync_o     (pins_sync)
    );

    logic dck_s;
    logic dms_s;
    logic ddi_s;
    logic dbg_reset_n_n_s;
    assign dbg_reset_n_n_s = pins_sync[3];
    assign dck_s    = pins_sync[2];
    assign dms_s    = pins_sync[1];
    assign ddi_s    = pins_sync[0];

    // debug unit reset: raw pin asserts at once, release waits two core edges
    // so no flop of the unit sees its reset drop close to a clock edge
    logic       pin_rst;
    logic [1:0] unit_rel_reg;
    logic       unit_rst;
    assign pin_rst = reset_i | ~dbg_reset_n_i;
    always_ff @(posedge core_clk_i or posedge pin_rst) begin
        if (pin_rst) begin
            unit_rel_reg <= 2'b00;
        end else if (clk_en_i) begin
            unit_rel_reg <= {unit_rel_reg[0], 1'b1};
        end
    end
    assign unit_rst = ~unit_rel_reg[1];

    logic dck_last_reg;
    logic rise;
    logic fall;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dck_last_reg <= 1'b1;
        end else if (clk_en_i) begin
            dck_last_reg <= dck_s;
        end
    end
    // edges of the probe clock as seen by the core clock; probe clock must be well below 20 MHz
    assign rise = dck_s & ~dck_last_reg & dbg_reset_n_n_s;
    assign fall = ~dck_s & dck_last_reg & dbg_reset_n_n_s;

    // interface state machine
    dstp_state_t state_reg;
    dstp_state_t state_next;
    always_comb begin
        unique case (state_reg)
            DSTP_RESET:    state_next = dms_s ? DSTP_RESET   : DSTP_IDLE;
            DSTP_IDLE:     state_next = dms_s ? DSTP_SEL_DR  : DSTP_IDLE;
            DSTP_SEL_DR:   state_next = dms_s ? DSTP_SEL_IR  : DSTP_CAP_DR;
            DSTP_CAP_DR:   state_next = dms_s ? DSTP_EXIT1_DR : DSTP_SHIFT_DR;
            DSTP_SHIFT_DR: state_next = dms_s ? DSTP_EXIT1_DR : DSTP_SHIFT_DR;
            DSTP_EXIT1_DR: state_next = dms_s ? DSTP_UPD_DR  : DSTP_PAUSE_DR;
            DSTP_PAUSE_DR: state_next = dms_s ? DSTP_EXIT2_DR : DSTP_PAUSE_DR;
            DSTP_EXIT2_DR: state_next = dms_s ? DSTP_UPD_DR  : DSTP_SHIFT_DR;
            DSTP_UPD_DR:   state_next = dms_s ? DSTP_SEL_DR  : DSTP_IDLE;
            DSTP_SEL_IR:   state_next = dms_s ? DSTP_RESET   : DSTP_CAP_IR;
            DSTP_CAP_IR:   state_next = dms_s ? DSTP_EXIT1_IR : DSTP_SHIFT_IR;
            DSTP_SHIFT_IR: state_next = dms_s ? DSTP_EXIT1_IR : DSTP_SHIFT_IR;
            DSTP_EXIT1_IR: state_next = dms_s ? DSTP_UPD_IR  : DSTP_PAUSE_IR;
            DSTP_PAUSE_IR: state_next = dms_s ? DSTP_EXIT2_IR : DSTP_PAUSE_IR;
            DSTP_EXIT2_IR: state_next = dms_s ? DSTP_UPD_IR  : DSTP_SHIFT_IR;
            DSTP_UPD_IR:   state_next = dms_s ? DSTP_SEL_DR  : DSTP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge unit_rst) begin
        if (unit_rst) begin
            state_reg <= DSTP_RESET;
        end else if (clk_en_i && rise) begin
            state_reg <= state_next;
        end
    end

    logic in_shift_dr;
    logic in_shift_ir;
    assign in_shift_dr = (state_reg == DSTP_SHIFT_DR);
    assign in_shift_ir = (state_reg == DSTP_SHIFT_IR);

    // shift registers: bit 0 goes out first, new bits enter at the top
    logic [DR_WIDTH-1:0] dr_reg;
    logic [IR_WIDTH-1:0] ir_reg;
    always_ff @(posedge core_clk_i or posedge unit_rst) begin
        if (unit_rst) begin
            dr_reg <= DSTP_DR_RESET[DR_WIDTH-1:0];
            ir_reg <= IR_WIDTH'(DSTP_IR_CAPTURE);
        end else if (clk_en_i && rise) begin
            if (state_reg == DSTP_CAP_DR) begin
                dr_reg <= dr_capture_i;
            end else if (in_shift_dr) begin
                dr_reg <= {ddi_s, dr_reg[DR_WIDTH-1:1]};
            end
            if (state_reg == DSTP_CAP_IR) begin
                ir_reg <= IR_WIDTH'(DSTP_IR_CAPTURE);
            end else if (in_shift_ir) begin
                ir_reg <= {ddi_s, ir_reg[IR_WIDTH-1:1]};
            end
        end
    end

    // update stage: parallel results change only in the update states
    always_ff @(posedge core_clk_i or posedge unit_rst) begin
        if (unit_rst) begin
            dr_update_o     <= DSTP_DR_RESET[DR_WIDTH-1:0];
            instr_o         <= IR_WIDTH'(DSTP_IR_RESET);
            dr_update_stb_o <= 1'b0;
            unit_enabled_o  <= 1'b0;
        end else if (clk_en_i) begin
            unit_enabled_o  <= 1'b1;
            dr_update_stb_o <= rise && (state_reg == DSTP_UPD_DR);
            if (rise && state_reg == DSTP_UPD_DR) begin
                dr_update_o <= dr_reg;
            end
            if (rise && state_reg == DSTP_UPD_IR) begin
                instr_o <= ir_reg;
            end
        end
    end

    // serial output launched at falling probe edges so it is stable for the next rising edge
    always_ff @(posedge core_clk_i or posedge unit_rst) begin
        if (unit_rst) begin
            dbg_serial_out_o    <= 1'b0;
            dbg_serial_out_oe_o <= 1'b0;
        end else if (clk_en_i && fall) begin
            dbg_serial_out_oe_o <= in_shift_dr | in_shift_ir;
            dbg_serial_out_o    <= in_shift_ir ? ir_reg[0] : dr_reg[0];
        end
    end

    // bus clock out: core clock divided by two; nibbles change with its rising edge
    logic [2:0]              nib_idx_reg;
    logic [DSTP_TRACE_W-1:0] trace_hold_reg;
    logic                    trace_busy_reg;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bus_clock_out_o <= 1'b0;
        end else if (clk_en_i) begin
            bus_clock_out_o <= ~bus_clock_out_o;
        end
    end

    // word taken when ready; nibbles leave lowest first, one per bus clock period
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            nib_idx_reg        <= 3'h0;
            trace_hold_reg     <= 32'h0000_0000;
            trace_busy_reg     <= 1'b0;
            trace_out_nibble_o <= 4'h0;
            trace_active_o     <= 1'b0;
            trace_ready_o      <= 1'b0;
        end else if (clk_en_i) begin
            trace_ready_o <= ~trace_busy_reg & ~(trace_valid_i & trace_ready_o);
            if (trace_valid_i && trace_ready_o) begin
                trace_hold_reg <= trace_word_i;
                trace_busy_reg <= 1'b1;
                nib_idx_reg    <= 3'h0;
                if (!bus_clock_out_o) begin
                    // no fresh nibble at this bus clock rise, so the pins are not valid
                    trace_active_o <= 1'b0;
                end
            end else if (!bus_clock_out_o && trace_busy_reg) begin
                // this core edge raises bus_clock_out, so the nibble moves with it
                trace_out_nibble_o <= trace_hold_reg[nib_idx_reg*4 +: 4];
                trace_active_o     <= 1'b1;
                nib_idx_reg        <= nib_idx_reg + 3'h1;
                if (nib_idx_reg == DSTP_NIB_LAST) begin
                    trace_busy_reg <= 1'b0;
                end
            end else if (!bus_clock_out_o) begin
                trace_active_o <= 1'b0;
            end
        end
    end
endmodule

/* verif/dstp_probe.sv */
// debug probe model: drives the serial port pins, paced by the core clock
`timescale 1ns/1ps
module dstp_probe (
    input  wire logic core_clk_i,
    input  wire logic tdo_i,
    output logic      sclk_o,
    output logic      ms_o,
    output logic      din_o,
    output logic      rst_n_o
);
    // unused levels; the clock stands high between frames
    initial begin
        sclk_o = 1'b1;
        ms_o = 1'b1;
        din_o = 1'b1;
        rst_n_o = 1'b0;
    end
    // one 200 ns link period: lines change while low, output read at the rise
    task automatic step(input logic ms, input logic di, output logic dout);
        @(posedge core_clk_i);
        sclk_o <= 1'b0;
        ms_o <= ms;
        din_o <= di;
        repeat (4) @(posedge core_clk_i);
        sclk_o <= 1'b1;
        #1 dout = tdo_i;
        repeat (3) @(posedge core_clk_i);
    endtask
endmodule

/* verif/dstp_chk.sv */
// checker: port relations of the debug serial trace port
`timescale 1ns/1ps
module dstp_chk (
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic       clk_en_i,
    input wire logic       dbg_reset_n_i,
    input wire logic       dbg_serial_clk_i,
    input wire logic       dbg_serial_out_o,
    input wire logic       dbg_serial_out_oe_o,
    input wire logic       unit_enabled_o,
    input wire logic       dr_update_stb_o,
    input wire logic       trace_ready_o,
    input wire logic       trace_active_o,
    input wire logic       bus_clock_out_o,
    input wire logic [3:0] trace_out_nibble_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    a_oe_dbg_reset: assert property (!dbg_reset_n_i |-> !dbg_serial_out_oe_o)
        else $error("serial out driven in debug reset");
    a_unit_dbg_reset: assert property (!dbg_reset_n_i |-> !unit_enabled_o)
        else $error("unit enabled in debug reset");
    a_oe_needs_unit: assert property (dbg_serial_out_oe_o |-> unit_enabled_o)
        else $error("serial out driven with unit off");
    // two cycles back the link clock must still be low, since output follows a fall
    a_out_after_fall: assert property ((dbg_serial_out_oe_o && $past(dbg_serial_out_oe_o)
        && $changed(dbg_serial_out_o)) |-> !$past(dbg_serial_clk_i, 2))
        else $error("serial out changed away from a falling edge");
    a_nibble_on_rise: assert property ($changed(trace_out_nibble_o) && trace_active_o
        |-> $rose(bus_clock_out_o)) else $error("nibble changed off a bus clock rise");
    a_bus_clock_div: assert property (clk_en_i |=> bus_clock_out_o != $past(bus_clock_out_o))
        else $error("bus clock did not toggle");
    a_busy_refuses: assert property ($rose(trace_active_o) |-> !trace_ready_o)
        else $error("trace ready while a word goes out");
    a_word_hold: assert property ($rose(trace_active_o) |-> trace_active_o [*8])
        else $error("trace word cut short");
    a_strobe_single: assert property (dr_update_stb_o |=> !dr_update_stb_o)
        else $error("update strobe longer than one cycle");
    c_update: cover property (dr_update_stb_o);
    c_trace: cover property ($rose(trace_active_o));
    c_shift: cover property ($rose(dbg_serial_out_oe_o));
endmodule
bind dstp_top dstp_chk chk (.*);

/* verif/dstp_tb_top.sv */
// testbench: probe scans and back-to-back trace words through the port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module dstp_tb_top
    import dstp_pkg::*;
;
    logic        core_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, trace_valid_i = 1'b0;
    logic        dbg_serial_clk_i, dbg_mode_select_i, dbg_serial_in_i, dbg_reset_n_i;
    logic        dbg_serial_out_o, dbg_serial_out_oe_o, dr_update_stb_o, unit_enabled_o;
    logic        trace_ready_o, bus_clock_out_o, trace_active_o, tdo_pin, tdo_last = 1'b0;
    logic [31:0] dr_capture_i = 32'hA5C3_0F96, dr_update_o, trace_word_i = 32'h0000_0000;
    logic [3:0]  instr_o, trace_out_nibble_o;
    int          fail_count = 0, checks_done = 0, stb_count = 0;
    dstp_top dut (.*);
    dstp_probe probe (.core_clk_i(core_clk_i), .tdo_i(tdo_pin), .sclk_o(dbg_serial_clk_i),
        .ms_o(dbg_mode_select_i), .din_o(dbg_serial_in_i), .rst_n_o(dbg_reset_n_i));
    always #12.5 core_clk_i = ~core_clk_i;
    // a released pin shows the inverse of its last level, so stale data cannot pass
    always @(posedge core_clk_i) if (dbg_serial_out_oe_o) tdo_last <= dbg_serial_out_o;
    assign tdo_pin = dbg_serial_out_oe_o ? dbg_serial_out_o : ~tdo_last;
    always @(posedge core_clk_i) if (dr_update_stb_o === 1'b1) stb_count++;
    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // five highs reach reset from anywhere, then idle, select, capture, shift
    task automatic enter_shift();
        logic b;
        for (int i = 0; i < 9; i++) probe.step(i < 5 || i == 6, 1'b1, b);
    endtask
    task automatic t_dbg_reset();
        `CHK("unit off", 1'b0, unit_enabled_o)
        @(posedge core_clk_i) probe.rst_n_o <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        `CHK("unit on", 1'b1, unit_enabled_o)
    endtask
    task automatic t_dr_scan(input logic [31:0] din);
        logic [31:0] dout;
        logic        b;
        int          s;
        s = stb_count;
        enter_shift();
        for (int i = 0; i < 32; i++) begin
            probe.step(i == 31, din[i], dout[i]);
            if (i < 31) `CHK("oe in shift", 1'b1, dbg_serial_out_oe_o)
        end
        probe.step(1'b1, 1'b1, b);
        probe.step(1'b0, 1'b1, b);
        // update lands at the edge the step ends on; let the strobe be counted
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK("scan out", dr_capture_i, dout)
        `CHK("scan in", din, dr_update_o)
        `CHK("update strobes", 1, stb_count - s)
        `CHK("oe in idle", 1'b0, dbg_serial_out_oe_o)
    endtask
    // the pin reset must act with no clock edge between drop and check
    task automatic t_reset_in_shift();
        logic b;
        enter_shift();
        probe.step(1'b0, 1'b1, b);
        `CHK("oe in shift", 1'b1, dbg_serial_out_oe_o)
        @(posedge core_clk_i) probe.rst_n_o <= 1'b0;
        #1;
        `CHK("oe async off", 1'b0, dbg_serial_out_oe_o)
        `CHK("unit async off", 1'b0, unit_enabled_o)
        t_dbg_reset();
    endtask
    // instruction scan with a pause in mid-shift: capture code out, new code in
    task automatic t_ir_scan(input logic [3:0] din);
        logic [3:0] dout;
        logic       b;
        for (int i = 0; i < 10; i++) probe.step(i < 5 || i == 6 || i == 7, 1'b1, b);
        for (int i = 0; i < 4; i++) begin
            probe.step(i == 1 || i == 3, din[i], dout[i]);
            if (i == 1) begin
                probe.step(1'b0, 1'b1, b);
                `CHK("oe in pause", 1'b0, dbg_serial_out_oe_o)
                probe.step(1'b1, 1'b1, b);
                probe.step(1'b0, 1'b1, b);
            end
        end
        probe.step(1'b1, 1'b1, b);
        probe.step(1'b0, 1'b1, b);
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK("ir out", DSTP_IR_CAPTURE, dout)
        `CHK("instr in", din, instr_o)
    endtask
    // clock enable low freezes the bus clock output, which resumes after
    task automatic t_freeze();
        logic bc;
        @(posedge core_clk_i) clk_en_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        bc = bus_clock_out_o;
        repeat (4) @(posedge core_clk_i);
        #1;
        `CHK("bus clock frozen", bc, bus_clock_out_o)
        @(posedge core_clk_i) clk_en_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        `CHK("bus clock resumed", ~bc, bus_clock_out_o)
    endtask
    task automatic t_trace();
        logic [63:0] words;
        logic [63:0] seen;
        int          n;
        words = 64'h0123_4567_89AB_CDEF;
        seen = '0;
        n = 0;
        fork
            begin
                @(posedge core_clk_i);
                for (int w = 0; w < 2; w++) begin
                    trace_valid_i <= 1'b1;
                    trace_word_i <= words[w*32 +: 32];
                    do @(posedge core_clk_i); while (trace_ready_o !== 1'b1);
                end
                trace_valid_i <= 1'b0;
            end
            for (int c = 0; c < 100 && n < 16; c++) begin
                @(posedge bus_clock_out_o);
                #1;
                if (trace_active_o === 1'b1) begin
                    seen[n*4 +: 4] = trace_out_nibble_o;
                    n++;
                end
            end
        join
        `CHK("trace nibbles", words, seen)
    endtask
    initial begin
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        t_dbg_reset();
        t_dr_scan(32'h3C96_5AF0);
        t_ir_scan(4'hA);
        t_reset_in_shift();
        t_dr_scan(32'hF00F_1234);
        t_trace();
        t_freeze();
        results();
    end
    // watchdog well past the roughly 25 us of scans and trace
    initial begin
        #200_000;
        fail_count++;
        results();
    end
endmodule
